// ===== maps_defines.svh
`ifndef MAPS_DEFINES_SVH
`define MAPS_DEFINES_SVH
`define MAPS_CLK_MHZ 200
`define MAPS_OFF_BIAS_US 2000
`define MAPS_OFF_BIAS_CYC ((`MAPS_OFF_BIAS_US * `MAPS_CLK_MHZ))
`define MAPS_HOLD_NS 100
`define MAPS_HOLD_CYC ((`MAPS_HOLD_NS * `MAPS_CLK_MHZ + 999) / 1000)
`define MAPS_REG_CTRL 32'h0000_0000
`define MAPS_REG_STAT 32'h0000_0004
`define MAPS_REG_IRQ 32'h0000_0008
`define MAPS_REG_MASK 32'h0000_000c
`define MAPS_CTRL_UP 0
`define MAPS_CTRL_DOWN 1
`define MAPS_CTRL_PARKED 2
`define MAPS_CTRL_BIAS_CMD 3
`define MAPS_IRQ_UP 0
`define MAPS_IRQ_OFF 1
`define MAPS_IRQ_LOSS 2
`define MAPS_IRQ_FAULT 3
`endif

// ===== maps_pkg.sv
`default_nettype none
package maps_pkg;
  typedef enum logic [7:0] {
    MAPS_OFF = 8'h01,
    MAPS_LOGIC = 8'h02,
    MAPS_OFFSET = 8'h04,
    MAPS_DELAY = 8'h08,
    MAPS_ON = 8'h10,
    MAPS_DRAIN = 8'h20,
    MAPS_HOLD = 8'h40,
    MAPS_EPARK = 8'h80
  } maps_state_t;
endpackage
`default_nettype wire

// ===== maps_sequencer.sv
// Our own choices: register access over Wishbone and the address map.
`include "maps_defines.svh"
`default_nettype none
module maps_sequencer #(
  parameter int unsigned OFF_BIAS_CYC = `MAPS_OFF_BIAS_CYC,
  parameter int unsigned HOLD_CYC = `MAPS_HOLD_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [31:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  output logic o_irq,
  output logic o_logic_supply_en,
  output logic o_io_supply_rail_en,
  output logic o_mirror_offset_rail_en,
  output logic o_mirror_bias_rail_en,
  output logic o_mirror_reset_rail_en,
  output logic o_power_down_n,
  output logic o_cmos_enable,
  output logic o_global_bias_cmd,
  input wire logic i_logic_supply_good,
  input wire logic i_io_supply_rail_good,
  input wire logic i_offset_rail_good,
  input wire logic i_mirror_rails_discharged,
  input wire logic i_reset_driver_out_enable_n,
  input wire logic i_power_loss
);
  // Bias delay may be shortened for simulation, but never to zero
  if (OFF_BIAS_CYC < 1) begin : g_bias_chk
    $error("offset_to_bias_delay too short");
  end
  // A hold below the rounded-up minimum would break the shutdown order
  if (HOLD_CYC < `MAPS_HOLD_CYC) begin : g_hold_chk
    $error("enable_to_good_hold too short");
  end

  logic [1:0] rst_sync_reg;
  logic rstn;
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rstn = rst_sync_reg[1];

  // Pin inputs through two flops; stage one read only by stage two
  logic [5:0] pin_s1_reg;
  logic [5:0] pin_s2_reg;
  always_ff @(posedge i_mclk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_reg <= 6'h00;
      pin_s2_reg <= 6'h00;
    end else begin
      pin_s1_reg <= {i_power_loss, i_reset_driver_out_enable_n, i_mirror_rails_discharged,
                     i_offset_rail_good, i_io_supply_rail_good, i_logic_supply_good};
      pin_s2_reg <= pin_s1_reg;
    end
  end
  wire logic_good = pin_s2_reg[0] & pin_s2_reg[1];
  wire off_good = pin_s2_reg[2];
  wire drained = pin_s2_reg[3];
  wire rdoe_high = pin_s2_reg[4];
  wire loss = pin_s2_reg[5];

  // Wishbone slave, one wait state, ack pulses once
  wire wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire wb_wr = wb_req & i_wb_we & i_wb_sel[0];
  wire sel_ctrl = (i_wb_adr == `MAPS_REG_CTRL);
  wire sel_stat = (i_wb_adr == `MAPS_REG_STAT);
  wire sel_irq = (i_wb_adr == `MAPS_REG_IRQ);
  wire sel_mask = (i_wb_adr == `MAPS_REG_MASK);
  wire cmd_up = wb_wr & sel_ctrl & i_wb_dat[`MAPS_CTRL_UP];
  wire cmd_down = wb_wr & sel_ctrl & i_wb_dat[`MAPS_CTRL_DOWN];
  wire cmd_parked = wb_wr & sel_ctrl & i_wb_dat[`MAPS_CTRL_PARKED];
  wire cmd_bias = wb_wr & sel_ctrl & i_wb_dat[`MAPS_CTRL_BIAS_CMD];

  maps_pkg::maps_state_t state_reg;
  maps_pkg::maps_state_t state_next;
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic parked_reg;
  logic [3:0] irq_reg;
  logic [3:0] mask_reg;
  logic [31:0] rdata_next;
  logic [3:0] ev;
  logic fault;

  wire cnt_done = (cnt_reg == 32'h0);
  wire [31:0] bias_load = 32'(OFF_BIAS_CYC - 1);
  wire [31:0] hold_load = 32'(HOLD_CYC - 1);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_done ? cnt_reg : cnt_reg - 32'h1;
    ev = 4'h0;
    fault = 1'b0;
    case (state_reg)
      maps_pkg::MAPS_OFF: begin
        if (cmd_up && rdoe_high && !loss) begin
          state_next = maps_pkg::MAPS_LOGIC;
        end
      end
      maps_pkg::MAPS_LOGIC: begin
        if (logic_good) begin
          state_next = maps_pkg::MAPS_OFFSET;
        end
      end
      maps_pkg::MAPS_OFFSET: begin
        if (off_good) begin
          state_next = maps_pkg::MAPS_DELAY;
          cnt_next = bias_load;
        end
      end
      maps_pkg::MAPS_DELAY: begin
        if (!off_good) begin
          fault = 1'b1;
          state_next = maps_pkg::MAPS_OFFSET;
        end else if (cnt_done) begin
          state_next = maps_pkg::MAPS_ON;
          ev[`MAPS_IRQ_UP] = 1'b1;
        end
      end
      maps_pkg::MAPS_ON: begin
        if (cmd_down && (parked_reg || cmd_parked)) begin
          state_next = maps_pkg::MAPS_HOLD;
          cnt_next = hold_load;
        end
      end
      maps_pkg::MAPS_HOLD: begin
        // Offset enable already low; good must outlive it
        if (!off_good && !cnt_done) begin
          fault = 1'b1;
        end
        if (cnt_done) begin
          state_next = maps_pkg::MAPS_DRAIN;
        end
      end
      maps_pkg::MAPS_EPARK: begin
        // Keep offset on until good drops, park done first
        if (!off_good) begin
          state_next = maps_pkg::MAPS_DRAIN;
          if (!rdoe_high) begin
            fault = 1'b1;
          end
        end
      end
      maps_pkg::MAPS_DRAIN: begin
        if (drained) begin
          state_next = maps_pkg::MAPS_OFF;
          ev[`MAPS_IRQ_OFF] = 1'b1;
        end
      end
      default: begin
        state_next = maps_pkg::MAPS_OFF;
      end
    endcase
    if (loss && (state_reg == maps_pkg::MAPS_OFFSET || state_reg == maps_pkg::MAPS_DELAY ||
                 state_reg == maps_pkg::MAPS_ON)) begin
      state_next = maps_pkg::MAPS_EPARK;
      ev[`MAPS_IRQ_LOSS] = 1'b1;
    end else if (loss && state_reg == maps_pkg::MAPS_LOGIC) begin
      state_next = maps_pkg::MAPS_DRAIN;
      ev[`MAPS_IRQ_LOSS] = 1'b1;
    end
    ev[`MAPS_IRQ_FAULT] = fault;
  end

  wire [3:0] irq_clr = (wb_wr && sel_irq) ? i_wb_dat[3:0] : 4'h0;
  wire [3:0] irq_next = (irq_reg & ~irq_clr) | ev;

  always_ff @(posedge i_mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= maps_pkg::MAPS_OFF;
      cnt_reg <= 32'h0;
      parked_reg <= 1'b0;
      irq_reg <= 4'h0;
      mask_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      irq_reg <= irq_next;
      if (wb_wr && sel_mask) begin
        mask_reg <= i_wb_dat[3:0];
      end
      if (state_reg != maps_pkg::MAPS_ON) begin
        parked_reg <= 1'b0;
      end else if (cmd_parked) begin
        parked_reg <= 1'b1;
      end
    end
  end

  wire st_mirror = (state_reg == maps_pkg::MAPS_OFFSET) || (state_reg == maps_pkg::MAPS_DELAY) ||
                   (state_reg == maps_pkg::MAPS_ON) || (state_reg == maps_pkg::MAPS_EPARK);
  wire st_supply = (state_reg != maps_pkg::MAPS_OFF);
  wire st_bias = (state_reg == maps_pkg::MAPS_ON) || (state_reg == maps_pkg::MAPS_EPARK);
  // Reset rail follows bias; no order needed between them
  wire st_reset_rail = st_bias;
  wire st_cmos = st_supply && logic_good && (state_reg != maps_pkg::MAPS_LOGIC) &&
                 (state_reg != maps_pkg::MAPS_DRAIN);

  always_comb begin
    rdata_next = 32'h0;
    if (sel_ctrl) begin
      rdata_next = {31'h0, parked_reg} << `MAPS_CTRL_PARKED;
    end else if (sel_stat) begin
      rdata_next = {18'h0, pin_s2_reg, state_reg};
    end else if (sel_irq) begin
      rdata_next = {28'h0, irq_reg};
    end else if (sel_mask) begin
      rdata_next = {28'h0, mask_reg};
    end
  end

  always_ff @(posedge i_mclk or negedge rstn) begin
    if (!rstn) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0;
      o_irq <= 1'b0;
      o_logic_supply_en <= 1'b0;
      o_io_supply_rail_en <= 1'b0;
      o_mirror_offset_rail_en <= 1'b0;
      o_mirror_bias_rail_en <= 1'b0;
      o_mirror_reset_rail_en <= 1'b0;
      o_power_down_n <= 1'b0;
      o_cmos_enable <= 1'b0;
      o_global_bias_cmd <= 1'b0;
    end else begin
      o_wb_ack <= wb_req;
      o_wb_dat <= wb_req ? rdata_next : 32'h0;
      o_irq <= |(irq_next & mask_reg);
      o_logic_supply_en <= (state_next != maps_pkg::MAPS_OFF);
      o_io_supply_rail_en <= (state_next != maps_pkg::MAPS_OFF);
      o_mirror_offset_rail_en <= st_mirror;
      o_mirror_bias_rail_en <= st_bias;
      o_mirror_reset_rail_en <= st_reset_rail;
      o_power_down_n <= st_mirror;
      o_cmos_enable <= st_cmos;
      o_global_bias_cmd <= cmd_bias && (state_reg == maps_pkg::MAPS_ON);
    end
  end
endmodule
`default_nettype wire

// ===== maps_checker.sv
`default_nettype none
module maps_checker #(
  parameter int unsigned OFF_BIAS_CYC = 20
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic o_logic_supply_en,
  input wire logic o_io_supply_rail_en,
  input wire logic o_mirror_offset_rail_en,
  input wire logic o_mirror_bias_rail_en,
  input wire logic o_mirror_reset_rail_en,
  input wire logic o_power_down_n,
  input wire logic o_cmos_enable,
  input wire logic o_global_bias_cmd,
  input wire logic i_logic_supply_good,
  input wire logic i_io_supply_rail_good,
  input wire logic i_offset_rail_good,
  input wire logic i_mirror_rails_discharged,
  input wire logic i_reset_driver_out_enable_n,
  input wire logic i_power_loss
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  int unsigned good_cnt;
  sequence rails_off_s;
    !o_mirror_offset_rail_en && !o_mirror_bias_rail_en && !o_mirror_reset_rail_en;
  endsequence
  // Saturates so a long on-time cannot wrap
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) good_cnt <= 0;
    else if (!i_offset_rail_good) good_cnt <= 0;
    else if (good_cnt < OFF_BIAS_CYC) good_cnt <= good_cnt + 1;
  end
  offset_order_a: assert property ($rose(o_mirror_offset_rail_en) |->
    o_logic_supply_en && i_logic_supply_good && i_io_supply_rail_good) else $error("offset early");
  bias_delay_a: assert property ($rose(o_mirror_bias_rail_en) |->
    good_cnt >= OFF_BIAS_CYC) else $error("bias too soon");
  cmos_low_a: assert property (o_cmos_enable |->
    i_logic_supply_good && i_io_supply_rail_good) else $error("cmos driven early");
  supply_keep_a: assert property ($fell(o_logic_supply_en) |->
    rails_off_s ##0 $past(i_mirror_rails_discharged, 2)) else $error("supply off early");
  hold_wait_a: assert property ($fell(o_mirror_offset_rail_en) |->
    (o_logic_supply_en && o_io_supply_rail_en) [*8]) else $error("no hold");
  rdoe_first_a: assert property ($rose(o_logic_supply_en) |->
    $past(i_reset_driver_out_enable_n, 3)) else $error("supply before rdoe");
  bias_pulse_a: assert property (o_global_bias_cmd |->
    o_mirror_bias_rail_en ##1 !o_global_bias_cmd) else $error("bias cmd bad");
  pdown_rails_a: assert property ($fell(o_power_down_n) |->
    ##[0:2] rails_off_s) else $error("rails up in power-down");
  epark_order_a: assert property ($fell(o_mirror_offset_rail_en) && i_power_loss |->
    !$past(i_offset_rail_good, 2)) else $error("offset dropped early");
  reset_idle_a: assert property (disable iff (1'b0) !i_rstn [*2] |->
    !o_logic_supply_en && !o_mirror_offset_rail_en && !o_power_down_n) else $error("reset");
endmodule
bind maps_sequencer maps_checker #(.OFF_BIAS_CYC(OFF_BIAS_CYC)) u_chk (.*);
`default_nettype wire

// ===== maps_rails_model.sv
`default_nettype none
module maps_rails_model (
  input wire logic i_clk,
  input wire logic i_loss,
  input wire logic i_sup_en,
  input wire logic i_off_en,
  input wire logic i_mir_en,
  output logic o_sup_good,
  output logic o_off_good,
  output logic o_disch
);
  timeunit 1ns;
  timeprecision 1ps;
  int sc = 0, oc = 0, hc = 0, ec = 0, dc = 0;
  logic og = 1'h0;
  always @(posedge i_clk) begin
    sc <= i_sup_en ? sc + 1 : 0;
    oc <= i_off_en ? oc + 1 : 0;
    // Unknown enables before reset must not poison the free-running counts
    hc <= (i_off_en !== 1'h0) ? 0 : hc + 1;
    ec <= i_loss ? ec + 1 : 0;
    dc <= (i_mir_en !== 1'h0) ? 0 : dc + 1;
    if (ec >= 6) og <= 1'h0;
    else if (oc >= 4) og <= 1'h1;
    else if (hc >= 24) og <= 1'h0;
  end
  assign o_sup_good = sc > 4;
  assign o_off_good = og;
  assign o_disch = dc > 10;
endmodule
`default_nettype wire

// ===== testbench.sv
`include "maps_defines.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk = 1'h0, i_rstn = 1'h0, i_wb_cyc = 1'h0, i_wb_stb = 1'h0, i_wb_we = 1'h0;
  logic [31:0] i_wb_adr = 32'h0, i_wb_dat = 32'h0, o_wb_dat;
  logic [3:0] i_wb_sel = 4'hf;
  logic i_power_loss = 1'h0, i_reset_driver_out_enable_n = 1'h1;
  logic o_wb_ack, o_irq, o_logic_supply_en, o_io_supply_rail_en, o_mirror_offset_rail_en;
  logic o_mirror_bias_rail_en, o_mirror_reset_rail_en, o_power_down_n, o_cmos_enable;
  logic o_global_bias_cmd, i_logic_supply_good, i_offset_rail_good, i_mirror_rails_discharged;
  int error_cnt = 0, tests_run = 0, cyc_cnt = 0, pulses = 0;
  wire logic i_io_supply_rail_good = i_logic_supply_good;
  initial forever #2.5 i_mclk = ~i_mclk;
  maps_sequencer #(.OFF_BIAS_CYC(20), .HOLD_CYC(20)) u_dut (.i_mclk, .i_rstn, .i_wb_cyc,
    .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .o_irq,
    .o_logic_supply_en, .o_io_supply_rail_en, .o_mirror_offset_rail_en, .o_mirror_bias_rail_en,
    .o_mirror_reset_rail_en, .o_power_down_n, .o_cmos_enable, .o_global_bias_cmd,
    .i_logic_supply_good, .i_io_supply_rail_good, .i_offset_rail_good,
    .i_mirror_rails_discharged, .i_reset_driver_out_enable_n, .i_power_loss);
  maps_rails_model u_rails (.i_clk(i_mclk), .i_loss(i_power_loss),
    .i_sup_en(o_logic_supply_en && o_io_supply_rail_en), .i_off_en(o_mirror_offset_rail_en),
    .i_mir_en(o_mirror_offset_rail_en || o_mirror_bias_rail_en || o_mirror_reset_rail_en),
    .o_sup_good(i_logic_supply_good), .o_off_good(i_offset_rail_good),
    .o_disch(i_mirror_rails_discharged));
  task automatic final_report;
    $display("errors=%0d checks=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard: the whole run needs a few hundred cycles
  always @(posedge i_mclk) begin
    cyc_cnt++;
    if (o_global_bias_cmd === 1'h1) pulses++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    i_wb_cyc <= 1'h1;
    i_wb_stb <= 1'h1;
    i_wb_we <= w;
    i_wb_adr <= a;
    i_wb_dat <= d;
    @(posedge i_mclk);
    while (o_wb_ack !== 1'h1) @(posedge i_mclk);
    q = o_wb_dat;
    i_wb_cyc <= 1'h0;
    i_wb_stb <= 1'h0;
    @(posedge i_mclk);
  endtask
  task automatic rd(input logic [31:0] a, e);
    logic [31:0] q;
    wb(1'h0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] q;
    wb(1'h1, a, d, q);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  task automatic t_refuse;
    i_reset_driver_out_enable_n <= 1'h0;
    settle(4);
    wr(`MAPS_REG_CTRL, 32'h1);
    settle(10);
    chk(32'(o_logic_supply_en), 32'h0);
    i_reset_driver_out_enable_n <= 1'h1;
    settle(4);
  endtask
  task automatic t_up;
    int n;
    wr(`MAPS_REG_MASK, 32'hf);
    wr(`MAPS_REG_CTRL, 32'h1);
    for (n = 0; n < 200 && i_offset_rail_good !== 1'h1; n++) @(posedge i_mclk);
    for (n = 0; n < 200 && o_mirror_bias_rail_en !== 1'h1; n++) @(posedge i_mclk);
    chk(32'(n >= 20), 32'h1);
    chk(32'(o_mirror_reset_rail_en), 32'h1);
    chk(32'(o_cmos_enable), 32'h1);
    chk(32'(o_irq), 32'h1);
    rd(`MAPS_REG_IRQ, 32'h1);
    wr(`MAPS_REG_IRQ, 32'h1);
    settle(2);
    chk(32'(o_irq), 32'h0);
  endtask
  task automatic t_bias;
    int p;
    p = pulses;
    wr(`MAPS_REG_CTRL, 32'h8);
    settle(3);
    chk(32'(pulses - p), 32'h1);
  endtask
  task automatic t_down;
    wr(`MAPS_REG_CTRL, 32'h2);
    settle(10);
    chk(32'(o_mirror_bias_rail_en), 32'h1);
    wr(`MAPS_REG_CTRL, 32'h6);
    for (int n = 0; n < 300 && o_logic_supply_en !== 1'h0; n++) @(posedge i_mclk);
    chk(32'({o_mirror_offset_rail_en, o_power_down_n, o_logic_supply_en}), 32'h0);
    chk(32'({o_io_supply_rail_en, o_mirror_reset_rail_en}), 32'h0);
    rd(`MAPS_REG_IRQ, 32'h2);
    wr(`MAPS_REG_IRQ, 32'hf);
  endtask
  task automatic t_loss;
    logic [31:0] q;
    wr(`MAPS_REG_CTRL, 32'h1);
    for (int n = 0; n < 300 && o_mirror_bias_rail_en !== 1'h1; n++) @(posedge i_mclk);
    i_power_loss <= 1'h1;
    for (int n = 0; n < 300 && o_logic_supply_en !== 1'h0; n++) @(posedge i_mclk);
    i_power_loss <= 1'h0;
    wb(1'h0, `MAPS_REG_IRQ, 32'h0, q);
    chk(q & 32'hd, 32'h5);
    chk(32'(o_irq), 32'h1);
    wr(`MAPS_REG_MASK, 32'h0);
    settle(2);
    chk(32'(o_irq), 32'h0);
  endtask
  initial begin
    settle(20);
    chk(32'({o_logic_supply_en, o_mirror_offset_rail_en, o_power_down_n}), 32'h0);
    i_rstn <= 1'h1;
    // Internal reset lags two edges, pin synchronisers two more
    settle(6);
    rd(`MAPS_REG_STAT, 32'h1801);
    rd(32'h10, 32'h0);
    t_refuse();
    t_up();
    t_bias();
    t_down();
    t_loss();
    final_report();
  end
endmodule
`default_nettype wire
